// ---- common/probe_pkg.sv ----
/*
  probe_pkg: shared constants for the probe sample and trigger block.
  assumes a 250 MHz clock; all users write probe_pkg::name.
*/
package probe_pkg;
  localparam int unsigned  CLK_HZ          = 250000000;
  localparam int unsigned  RATE_MIN_HZ     = 50;
  localparam int unsigned  RATE_MAX_HZ     = 2000;
  localparam int unsigned  DIV_MAX         = CLK_HZ / RATE_MIN_HZ;
  localparam int unsigned  DIV_MIN         = CLK_HZ / RATE_MAX_HZ;
  localparam int unsigned  DATA_W          = 16;
  localparam int unsigned  FIFO_DEPTH      = 8;
  localparam int unsigned  CHAN_W          = 2;
  localparam int unsigned  GAIN_W          = 4;
  localparam int unsigned  PULSE_NS        = 40;
  localparam int unsigned  CLK_PERIOD_NS   = 4;
  localparam int unsigned  PULSE_CYC       = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0]  THRESH_RST      = 16'h0000;
  localparam logic [3:0]   GAIN_RST        = 4'h1;
  localparam logic [1:0]   ST_OK           = 2'h0;
  localparam logic [1:0]   ST_BUSY         = 2'h1;
  localparam logic [1:0]   ST_DROP         = 2'h2;
  localparam logic [1:0]   ST_BAD          = 2'h3;

  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_SAMPLE    = 4'h1,
    CMD_SAMPLE_UNITS = 4'h2,
    CMD_RATE      = 4'h3,
    CMD_READ_LAST = 4'h4,
    CMD_READ_ALL  = 4'h5,
    CMD_CLEAR     = 4'h6,
    CMD_RESET     = 4'h7,
    CMD_TRIG_ARM  = 4'h8,
    CMD_TOUCH_ARM = 4'h9,
    CMD_THRESH    = 4'ha,
    CMD_CRASH_ARM = 4'hb,
    CMD_GAIN      = 4'hc,
    CMD_STOP      = 4'hd
  } cmd_type;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_WAIT = 2'b01
  } conv_type;
endpackage

// ---- rtl/probe_fifo.sv ----
/*
  probe_fifo: flip-flop fifo with valid/ready on both sides.
  assumes one clock and an async active-high reset.
*/
`timescale 1ns/1ps
module probe_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_state_type;

  fifo_state_type s_q;
  fifo_state_type s_d;
  logic           push;
  logic           pop;

  // ==========================================
  // next state
  always_comb begin
    s_d  = s_q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) begin
      s_d.wp  = '0;
      s_d.rp  = '0;
      s_d.cnt = '0;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = (s_q.cnt != DEPTH[AW:0]);
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign count     = s_q.cnt;
endmodule

// ---- rtl/probe_sampler.sv ----
/*
  probe_sampler: probe sampling, triggering, threshold and sync events.
  assumes a converter handshake (conv_start/conv_done), synchronous inputs,
  and a single command port with one-cycle strobes.
*/
`timescale 1ns/1ps
// What this block does
// - sample command stores raw digitized value
// - converting sample stores engineering_units result
// - periodic sampling at programmed rate
// - read-last shows newest sample, fifo untouched
// - read-all streams fifo out in order
// - clear command empties the fifo
// - armed trigger samples on sync event
// - sync input level change triggers sample
// - programmable threshold loaded by command
// - touch emulation raises event at threshold
// - crash detection raises its own event
// - event shown as pulse or level toggle
// - per channel amplifier gain is configurable
// - report in-range and contact flags
// - status of last sample and configure
// - rates from 50 to 2000 hz served
// - polled and scan rates 50 to 2000 hz
module probe_sampler #(
  parameter int unsigned DATA_W   = probe_pkg::DATA_W,
  parameter int unsigned DEPTH    = probe_pkg::FIFO_DEPTH,
  parameter int unsigned NCHAN    = 4,
  parameter int unsigned DIV_MAXP = probe_pkg::DIV_MAX
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   cmd_valid,
  input  wire logic [3:0]             cmd_code,
  input  wire logic [1:0]             cmd_chan,
  input  wire logic [DATA_W-1:0]      cmd_arg,
  input  wire logic                   cmd_alt,
  output logic                        conv_start,
  output logic [1:0]                  conv_chan,
  output logic [3:0]                  conv_gain,
  output logic                        conv_units,
  input  wire logic                   conv_done,
  input  wire logic [DATA_W-1:0]      conv_data,
  input  wire logic                   sync_in,
  output logic                        sync_touch,
  output logic                        sync_crash,
  input  wire logic                   in_range_raw,
  input  wire logic                   contact_raw,
  input  wire logic                   crash_raw,
  output logic                        in_range,
  output logic                        contact,
  output logic [DATA_W-1:0]           last_sample,
  output logic                        last_valid,
  output logic [DATA_W-1:0]           out_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [$clog2(DEPTH):0]      sample_count,
  output logic                        overflow,
  output logic [1:0]                  sample_status,
  output logic [1:0]                  config_status
);
  localparam int unsigned CW = $clog2(DEPTH);
  initial begin
    if (NCHAN > 4 || NCHAN < 1) $error("channel count must be 1 to 4");
    if (DIV_MAXP < 2) $error("rate divider too small");
  end

  typedef struct packed {
    probe_pkg::conv_type         conv;
    logic [1:0]                  chan;
    logic                        units;
    logic [NCHAN-1:0][3:0]       gain;
    logic [DATA_W-1:0]           thresh;
    logic [31:0]                 period;
    logic [31:0]                 tick;
    logic                        rate_on;
    logic                        trig_arm;
    logic                        trig_level;
    logic                        sync_prev;
    logic                        touch_on;
    logic                        touch_lvl;
    logic                        crash_on;
    logic                        crash_lvl;
    logic                        touch_done;
    logic                        crash_done;
    logic                        touch_o;
    logic                        crash_o;
    logic                        start_o;
    logic [3:0]                  gain_o;
    logic [DATA_W-1:0]           last;
    logic                        last_v;
    logic                        drain;
    logic                        ovf;
    logic                        pend;
    logic [1:0]                  sst;
    logic [1:0]                  cst;
    logic                        rng;
    logic                        cnt;
    logic [DATA_W-1:0]           odata;
    logic                        ovalid;
  } state_type;

  state_type            s_q;
  state_type            s_d;
  logic                 f_in_valid;
  logic                 f_in_ready;
  logic [DATA_W-1:0]    f_out_data;
  logic                 f_out_valid;
  logic                 f_out_ready;
  logic                 f_flush;
  logic [CW:0]          f_count;
  logic                 trig;
  logic                 drop;
  probe_pkg::cmd_type   cmd;

  function automatic logic [31:0] rate_div(input logic [DATA_W-1:0] hz);
    if (hz < DATA_W'(probe_pkg::RATE_MIN_HZ) || hz > DATA_W'(probe_pkg::RATE_MAX_HZ)) begin
      rate_div = 32'h0;
    end else begin
      rate_div = probe_pkg::CLK_HZ / {16'h0, hz};
    end
  endfunction

  probe_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (f_flush),
    .in_data   (conv_data),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .count     (f_count)
  );

  // ==========================================
  // next state
  always_comb begin
    s_d        = s_q;
    cmd        = cmd_valid ? probe_pkg::cmd_type'(cmd_code) : probe_pkg::CMD_NONE;
    trig       = 1'b0;
    drop       = 1'b0;
    f_flush    = 1'b0;
    f_in_valid = 1'b0;
    s_d.start_o   = 1'b0;
    s_d.sync_prev = sync_in;
    s_d.rng       = in_range_raw;
    s_d.cnt       = contact_raw;
    // periodic tick
    if (s_q.rate_on) begin
      if (s_q.tick == 32'h0) begin
        s_d.tick = s_q.period - 32'h1;
        trig     = 1'b1;
      end else begin
        s_d.tick = s_q.tick - 32'h1;
      end
    end
    // sync trigger: pulse edge or any level change
    if (s_q.trig_arm) begin
      if (s_q.trig_level) begin
        trig = trig | (sync_in != s_q.sync_prev);
      end else begin
        trig = trig | (sync_in && !s_q.sync_prev);
      end
    end
    // conversion handshake
    case (s_q.conv)
      probe_pkg::CONV_IDLE: begin
        if (trig) begin
          s_d.start_o = 1'b1;
          s_d.conv    = probe_pkg::CONV_WAIT;
          s_d.sst     = probe_pkg::ST_BUSY;
        end
      end
      probe_pkg::CONV_WAIT: begin
        if (trig) begin
          drop    = 1'b1;
          s_d.sst = probe_pkg::ST_DROP;
        end
        if (conv_done) begin
          s_d.conv   = probe_pkg::CONV_IDLE;
          s_d.last   = conv_data;
          s_d.last_v = 1'b1;
          if (f_in_ready) begin
            f_in_valid = 1'b1;
            if (!trig) s_d.sst = probe_pkg::ST_OK;
          end else begin
            drop    = 1'b1;
            s_d.sst = probe_pkg::ST_DROP;
          end
        end
      end
      default: s_d.conv = probe_pkg::CONV_IDLE;
    endcase
    // threshold and crash events
    if (s_q.touch_on && !s_q.touch_done && s_d.last_v && s_d.last >= s_q.thresh) begin
      s_d.touch_done = 1'b1;
      s_d.touch_o    = s_q.touch_lvl ? !s_q.touch_o : 1'b1;
    end else if (!s_q.touch_lvl) begin
      s_d.touch_o = 1'b0;
    end
    if (s_q.touch_done && s_d.last < s_q.thresh) s_d.touch_done = 1'b0;
    if (s_q.crash_on && !s_q.crash_done && crash_raw) begin
      s_d.crash_done = 1'b1;
      s_d.crash_o    = s_q.crash_lvl ? !s_q.crash_o : 1'b1;
    end else if (!s_q.crash_lvl) begin
      s_d.crash_o = 1'b0;
    end
    if (!crash_raw) s_d.crash_done = 1'b0;
    // read-out path
    f_out_ready = s_q.drain && (!s_q.ovalid || out_ready);
    if (s_q.ovalid && out_ready) s_d.ovalid = 1'b0;
    if (f_out_ready && f_out_valid) begin
      s_d.odata  = f_out_data;
      s_d.ovalid = 1'b1;
    end
    if (s_q.drain && !f_out_valid) s_d.drain = 1'b0;
    // commands
    case (cmd)
      probe_pkg::CMD_SAMPLE, probe_pkg::CMD_SAMPLE_UNITS: begin
        if (s_q.conv == probe_pkg::CONV_IDLE && !trig) begin
          s_d.chan    = cmd_chan;
          s_d.units   = (cmd == probe_pkg::CMD_SAMPLE_UNITS);
          s_d.start_o = 1'b1;
          s_d.conv    = probe_pkg::CONV_WAIT;
          s_d.sst     = probe_pkg::ST_BUSY;
        end else begin
          s_d.sst = probe_pkg::ST_DROP;
        end
      end
      probe_pkg::CMD_RATE: begin
        if (rate_div(cmd_arg) == 32'h0 || rate_div(cmd_arg) > DIV_MAXP) begin
          s_d.cst = probe_pkg::ST_BAD;
        end else begin
          s_d.chan    = cmd_chan;
          s_d.units   = cmd_alt;
          s_d.period  = rate_div(cmd_arg);
          s_d.tick    = rate_div(cmd_arg) - 32'h1;
          s_d.rate_on = 1'b1;
          s_d.cst     = probe_pkg::ST_OK;
        end
      end
      probe_pkg::CMD_STOP:      s_d.rate_on = 1'b0;
      probe_pkg::CMD_READ_LAST: if (!s_q.drain && !s_q.ovalid) s_d.odata = s_q.last;
      probe_pkg::CMD_READ_ALL:  s_d.drain   = 1'b1;
      probe_pkg::CMD_CLEAR: begin
        f_flush    = 1'b1;
        f_in_valid = 1'b0;
        s_d.ovf    = 1'b0;
        s_d.drain  = 1'b0;
      end
      probe_pkg::CMD_TRIG_ARM: begin
        s_d.chan       = cmd_chan;
        s_d.units      = cmd_arg[1];
        s_d.trig_arm   = cmd_arg[0];
        s_d.trig_level = cmd_alt;
        s_d.cst        = probe_pkg::ST_OK;
      end
      probe_pkg::CMD_TOUCH_ARM: begin
        s_d.touch_on  = cmd_arg[0];
        s_d.touch_lvl = cmd_alt;
        s_d.touch_o   = 1'b0;
        s_d.cst       = probe_pkg::ST_OK;
      end
      probe_pkg::CMD_CRASH_ARM: begin
        s_d.crash_on  = cmd_arg[0];
        s_d.crash_lvl = cmd_alt;
        s_d.crash_o   = 1'b0;
        s_d.cst       = probe_pkg::ST_OK;
      end
      probe_pkg::CMD_THRESH: begin
        s_d.thresh = cmd_arg;
        s_d.cst    = probe_pkg::ST_OK;
      end
      probe_pkg::CMD_GAIN: begin
        if (32'(cmd_chan) < NCHAN) begin
          s_d.gain[cmd_chan] = cmd_arg[3:0];
          s_d.cst            = probe_pkg::ST_OK;
        end else begin
          s_d.cst = probe_pkg::ST_BAD;
        end
      end
      probe_pkg::CMD_RESET: begin
        s_d        = '0;
        s_d.rng       = in_range_raw;
        s_d.cnt       = contact_raw;
        s_d.sync_prev = sync_in;
        s_d.thresh = probe_pkg::THRESH_RST;
        for (int i = 0; i < NCHAN; i++) s_d.gain[i] = probe_pkg::GAIN_RST;
        f_flush    = 1'b1;
        f_in_valid = 1'b0;
      end
      probe_pkg::CMD_NONE: ;
      default: begin
        if (cmd_valid) s_d.cst = probe_pkg::ST_BAD;
      end
    endcase
    // a drop in the cycle of a clear still sets the flag
    if (drop) s_d.ovf = 1'b1;
    s_d.gain_o = s_d.gain[s_d.chan];
  end

  // ==========================================
  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      for (int i = 0; i < NCHAN; i++) s_q.gain[i] <= probe_pkg::GAIN_RST;
      s_q.thresh <= probe_pkg::THRESH_RST;
      s_q.gain_o <= probe_pkg::GAIN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs, all from flip-flops
  assign conv_start    = s_q.start_o;
  assign conv_chan     = s_q.chan;
  assign conv_gain     = s_q.gain_o;
  assign conv_units    = s_q.units;
  assign sync_touch    = s_q.touch_o;
  assign sync_crash    = s_q.crash_o;
  assign in_range      = s_q.rng;
  assign contact       = s_q.cnt;
  assign last_sample   = s_q.last;
  assign last_valid    = s_q.last_v;
  assign out_data      = s_q.odata;
  assign out_valid     = s_q.ovalid;
  assign sample_count  = f_count;
  assign overflow      = s_q.ovf;
  assign sample_status = s_q.sst;
  assign config_status = s_q.cst;
endmodule

// ---- tb/probe_sampler_assertions.sv ----
/*
  probe_sampler_assertions: port checks for probe_sampler.
  assumes the bind below reaches each probe_sampler.
*/
`timescale 1ns/1ps
module probe_sampler_assertions #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned DEPTH  = 8
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   cmd_valid,
  input wire logic [3:0]             cmd_code,
  input wire logic                   conv_start,
  input wire logic                   conv_units,
  input wire logic                   conv_done,
  input wire logic [DATA_W-1:0]      conv_data,
  input wire logic                   in_range_raw,
  input wire logic                   contact_raw,
  input wire logic                   in_range,
  input wire logic                   contact,
  input wire logic [DATA_W-1:0]      last_sample,
  input wire logic [DATA_W-1:0]      out_data,
  input wire logic                   out_valid,
  input wire logic                   out_ready,
  input wire logic [$clog2(DEPTH):0] sample_count,
  input wire logic                   overflow,
  input wire logic [1:0]             sample_status
);
  // ==========
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic idle;
  logic full;
  logic busy_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (conv_start) begin
      busy_q <= 1'b1;
    end else if (conv_done) begin
      busy_q <= 1'b0;
    end
  end
  assign idle = cmd_valid && sample_status != probe_pkg::ST_BUSY && !conv_start && !busy_q;
  assign full = 32'(sample_count) >= DEPTH;
  raw_start_a:
    assert property (idle && cmd_code == probe_pkg::CMD_SAMPLE |=> conv_start && !conv_units)
    else $error("raw sample gave no start");
  units_start_a:
    assert property (idle && cmd_code == probe_pkg::CMD_SAMPLE_UNITS |=> conv_start && conv_units)
    else $error("converted sample gave no start");
  last_take_a:
    assert property (conv_done && !full |=> last_sample == $past(conv_data))
    else $error("last sample not taken");
  clear_empty_a:
    assert property (cmd_valid && cmd_code == probe_pkg::CMD_CLEAR && !conv_done |=> sample_count == 0 && !overflow)
    else $error("clear left data");
  count_up_a:
    assert property (conv_done && !full && !cmd_valid && !out_valid |=> sample_count == $past(sample_count) + 1)
    else $error("count did not step");
  ovf_set_a:
    assert property (conv_done && full && !cmd_valid && !out_valid |=> overflow && full)
    else $error("overflow not flagged");
  flag_delay_a:
    assert property (!$past(rst) |-> in_range == $past(in_range_raw) && contact == $past(contact_raw))
    else $error("probe flags wrong");
  drain_start_a:
    assert property (cmd_valid && cmd_code == probe_pkg::CMD_READ_ALL && sample_count != 0 && !out_valid |-> ##2 out_valid)
    else $error("read-out did not start");
  out_hold_a:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word moved");
  cover property (conv_done && full);
  cover property (out_valid && out_ready);
  cover property ($rose(overflow));
endmodule

bind probe_sampler probe_sampler_assertions #(.DATA_W(DATA_W), .DEPTH(DEPTH)) chk_i (
  .clk, .rst, .cmd_valid, .cmd_code, .conv_start, .conv_units, .conv_done, .conv_data, .in_range_raw,
  .contact_raw, .in_range, .contact, .last_sample, .out_data, .out_valid, .out_ready, .sample_count,
  .overflow, .sample_status
);

// ---- tb/conv_model.sv ----
/*
  conv_model: converter behind probe_sampler.
  assumes dly of at least one cycle; result tags channel, gain and units.
*/
`timescale 1ns/1ps
module conv_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        conv_start,
  input  wire logic [1:0]  conv_chan,
  input  wire logic [3:0]  conv_gain,
  input  wire logic        conv_units,
  input  wire logic [8:0]  val,
  input  wire logic [7:0]  dly,
  output logic             conv_done,
  output logic [15:0]      conv_data
);
  // ==========
  // conversion
  logic [7:0]  n;
  logic [15:0] held;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      n <= 8'h0;
      conv_done <= 1'b0;
      conv_data <= 16'hffff;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        held <= {val, conv_units, conv_gain, conv_chan};
        n <= dly;
      end else if (n == 8'h1) begin
        conv_done <= 1'b1;
        conv_data <= held;
        n <= 8'h0;
      end else if (n > 8'h1) begin
        n <= n - 8'h1;
      end
    end
  end
endmodule

// ---- tb/test_probe_sampler.sv ----
/*
  test_probe_sampler: command bench for probe_sampler.
  assumes conv_model as converter and the bound checker.
*/
`timescale 1ns/1ps
module test_probe_sampler;
  logic        clk = 1'h0, rst = 1'h1, cmd_valid = 1'h0, cmd_alt = 1'h0, sync_in = 1'h0, out_ready = 1'h0;
  logic        in_range_raw = 1'h0, contact_raw = 1'h0, crash_raw = 1'h0;
  logic [3:0]  cmd_code = 4'h0;
  logic [1:0]  cmd_chan = 2'h0;
  logic [15:0] cmd_arg = 16'h0;
  logic [8:0]  val = 9'h0;
  logic [7:0]  dly = 8'h1;
  logic        conv_start, conv_units, conv_done, sync_touch, sync_crash, in_range, contact;
  logic        last_valid, out_valid, overflow;
  logic [1:0]  conv_chan, sample_status, config_status;
  logic [3:0]  conv_gain, sample_count;
  logic [15:0] conv_data, last_sample, out_data;
  logic [15:0] q[$];
  logic [15:0] rates[3] = '{16'h0031, 16'h07d1, 16'h07d0};
  logic [3:0]  gain[4] = '{default: 4'h1};
  int          fail_count = 0, checks = 0, cyc = 0, touches = 0, pos = 0, i, j;

  probe_sampler #(.DEPTH(8)) uut (.clk, .rst, .cmd_valid, .cmd_code, .cmd_chan, .cmd_arg, .cmd_alt,
    .conv_start, .conv_chan, .conv_gain, .conv_units, .conv_done, .conv_data, .sync_in, .sync_touch,
    .sync_crash, .in_range_raw, .contact_raw, .crash_raw, .in_range, .contact, .last_sample,
    .last_valid, .out_data, .out_valid, .out_ready, .sample_count, .overflow, .sample_status,
    .config_status);
  conv_model far (.clk, .rst, .conv_start, .conv_chan, .conv_gain, .conv_units, .val, .dly, .conv_done,
    .conv_data);

  // ==========
  // clock, timeout, monitors
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (sync_touch === 1'b1) touches++;
    if (cyc == 6000) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========
  // tasks
  task automatic finish_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [3:0] c, input logic [1:0] ch, input logic [15:0] a, input logic al);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_chan = ch;
    cmd_arg = a;
    cmd_alt = al;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_done;
    for (j = 0; j < 200 && conv_done !== 1'b1; j++) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic fin(input logic [1:0] ch, input logic units, input logic [8:0] v);
    logic [15:0] e;
    e = {v, units, gain[ch], ch};
    if (q.size() < 8) begin
      q.push_back(e);
      chk(last_sample, e);
    end
  endtask
  task automatic samp(input logic [3:0] c, input logic [1:0] ch, input logic [8:0] v);
    val = v;
    send(c, ch, 16'h0, 1'b0);
    wait_done();
    fin(ch, c == probe_pkg::CMD_SAMPLE_UNITS, v);
  endtask
  task automatic trig(input logic lvl);
    @(negedge clk);
    sync_in = lvl;
    val = 9'(pos);
    wait_done();
    fin(2'h0, 1'b0, val);
    pos++;
  endtask

  // ==========
  // sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(16'({last_valid, conv_gain, sample_count, overflow, sample_status, config_status}), 16'h200);
    send(probe_pkg::CMD_GAIN, 2'h2, 16'h5, 1'b0);
    gain[2] = 4'h5;
    chk(16'(config_status), 16'(probe_pkg::ST_OK));
    samp(probe_pkg::CMD_SAMPLE, 2'h2, 9'h0a5);
    dly = 8'h14;
    val = 9'h13c;
    send(probe_pkg::CMD_SAMPLE_UNITS, 2'h1, 16'h0, 1'b0);
    send(probe_pkg::CMD_SAMPLE, 2'h0, 16'h0, 1'b0);
    chk(16'(sample_status), 16'(probe_pkg::ST_DROP));
    wait_done();
    fin(2'h1, 1'b1, 9'h13c);
    dly = 8'h1;
    send(probe_pkg::CMD_READ_LAST, 2'h0, 16'h0, 1'b0);
    @(negedge clk);
    chk(out_data, q[$]);
    chk(16'({last_valid, out_valid, sample_count}), 16'h22);
    send(4'hf, 2'h0, 16'h0, 1'b0);
    chk(16'(config_status), 16'(probe_pkg::ST_BAD));
    for (i = 0; i < 3; i++) begin
      send(probe_pkg::CMD_RATE, 2'h0, rates[i], 1'b0);
      chk(16'(config_status), 16'(i < 2 ? probe_pkg::ST_BAD : probe_pkg::ST_OK));
      send(probe_pkg::CMD_STOP, 2'h0, 16'h0, 1'b0);
    end
    send(probe_pkg::CMD_THRESH, 2'h0, 16'h4000, 1'b0);
    send(probe_pkg::CMD_TOUCH_ARM, 2'h0, 16'h1, 1'b0);
    samp(probe_pkg::CMD_SAMPLE, 2'h0, 9'h0ff);
    samp(probe_pkg::CMD_SAMPLE, 2'h0, 9'h010);
    repeat (2) @(negedge clk);
    chk(16'(touches), 16'h1);
    send(probe_pkg::CMD_CRASH_ARM, 2'h0, 16'h1, 1'b1);
    crash_raw = 1'b1;
    in_range_raw = 1'b1;
    contact_raw = 1'b1;
    repeat (3) @(negedge clk);
    chk(16'({sync_crash, sync_touch, in_range, contact}), 16'hb);
    crash_raw = 1'b0;
    send(probe_pkg::CMD_CLEAR, 2'h0, 16'h0, 1'b0);
    q.delete();
    chk(16'(sample_count), 16'h0);
    send(probe_pkg::CMD_TRIG_ARM, 2'h0, 16'h1, 1'b1);
    for (i = 0; i < 3; i++) trig(~sync_in);
    send(probe_pkg::CMD_TRIG_ARM, 2'h0, 16'h1, 1'b0);
    sync_in = 1'b0;
    repeat (6) @(negedge clk);
    trig(1'b1);
    chk(16'(sample_count), 16'(pos));
    for (i = 0; i < 5; i++) samp(probe_pkg::CMD_SAMPLE, 2'h3, 9'(i + 32));
    chk(16'({overflow, sample_count}), 16'h18);
    send(probe_pkg::CMD_READ_ALL, 2'h0, 16'h0, 1'b0);
    for (i = 0; i < 8; i++) begin
      for (j = 0; j < 20 && out_valid !== 1'b1; j++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk(out_data, q.pop_front());
      out_ready = 1'b1;
      @(negedge clk);
      out_ready = 1'b0;
    end
    repeat (4) @(negedge clk);
    chk(16'({out_valid, sample_count}), 16'h0);
    send(probe_pkg::CMD_RESET, 2'h0, 16'h0, 1'b0);
    chk(16'({last_valid, overflow, sample_count, sample_status, config_status}), 16'h0);
    finish_test();
  end
endmodule
